//--- verilog/bridge_pkg.sv
// Package for the half-bridge serial control and status block
// Assumes a 16-bit control word and a 16-bit status word, LSB first on the link
package bridge_pkg;
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    // Control word bit positions
    localparam int CTL_CLEAR = 0;
    localparam int CTL_LOW_A = 3;
    localparam int CTL_HIGH_A = 4;
    localparam int CTL_LOW_B = 7;
    localparam int CTL_HIGH_B = 8;
    localparam int CTL_LOW_C = 11;
    localparam int CTL_HIGH_C = 12;
    localparam int CTL_OPEN_N = 13;
    localparam int CTL_SHORT_DLY = 14;
    localparam int CTL_SOFT_EN = 15;
    // Status word bit positions
    localparam int ST_PREWARN = 0;
    localparam int ST_SHORT = 13;
    localparam int ST_ENABLE = 14;
    localparam int ST_SUPPLY = 15;
    // Control word after power-on: enable, short delay, open-load off high
    localparam logic [15:0] CTL_RESET = 16'hE000;
    localparam logic [15:0] ALL_ONES = 16'hFFFF;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [5:0] SW_OFF = 6'h00;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_FULL = 5'h10;
endpackage

//--- verilog/bridge_link.sv
// Serial link shifter running on the link clock
// Assumes the host clock stands idle low between frames and only cs_n frames it
`timescale 1ns/1ps
module bridge_link
    import bridge_pkg::*;
(
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic [15:0] status_word,
    output logic serial_out,
    output logic [15:0] rx_word,
    output logic [4:0] rx_count
);
    logic [15:0] rx_q;
    logic [4:0] cnt_q;
    logic [4:0] end_cnt_q;
    logic [4:0] tx_cnt_q;
    logic [15:0] shot_q;

    // Snapshot of status at frame start
    always_ff @(negedge cs_n)
        shot_q <= status_word;

    // Sample data on falling clock, LSB first
    always_ff @(negedge link_clk)
    begin
        if (!cs_n)
            rx_q <= {serial_in, rx_q[15:1]};
    end

    // Count received bits; saturates so longer frames still count as full
    always_ff @(negedge link_clk or posedge cs_n)
    begin
        if (cs_n)
            cnt_q <= CNT_ZERO;
        else if (cnt_q != CNT_FULL)
            cnt_q <= cnt_q + 5'h01;
    end

    // Keep the bit count of the frame that just ended for the system side
    always_ff @(posedge cs_n)
        end_cnt_q <= cnt_q;

    // Transmit index moves on rising clock; bit 0 is shown from cs fall
    always_ff @(posedge link_clk or posedge cs_n)
    begin
        if (cs_n)
            tx_cnt_q <= CNT_ZERO;
        else if (tx_cnt_q != CNT_FULL)
            tx_cnt_q <= tx_cnt_q + 5'h01;
    end

    assign serial_out = tx_cnt_q[4] ? 1'b0 : shot_q[tx_cnt_q[3:0]];
    assign rx_word = rx_q;
    assign rx_count = end_cnt_q;
endmodule // bridge_link

//--- verilog/bridge_ctrl.sv
// What this block does
// - Status bit 0 shows thermal pre-warning
// - Switch status bits show switch on state
// - Open-load mode: switch bits show open load
// - Bit 13 set on short-circuit turn-off
// - Bit 14 shows soft and pin enable
// - Bit 15 set on supply under-voltage
// - Over-temperature shutdown reads all ones
// - Control reset: enable, delay, open-load high
// - Either enable low turns outputs off
// - Outputs return only when both enables high
// - Open-load bit low enables pull-downs
// - Open-load status follows the open load
// - Frame starts cs fall, applies cs rise
// - Input sampled falling clock, LSB first
// - Output changes rising clock, tri-state idle
// - Control bit 0 clears latched faults
// File: control and status logic of the triple half-bridge serial link
// Assumes analog monitors arrive asynchronously; link runs on its own clock
`timescale 1ns/1ps
module bridge_ctrl
    import bridge_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    input wire logic hw_enable,
    input wire logic temp_warn_in,
    input wire logic temp_shut_in,
    input wire logic short_in,
    input wire logic uv_in,
    input wire logic [5:0] open_in,
    output logic [5:0] switch_on,
    output logic open_pull_en,
    output logic short_delay_long
);
    logic [15:0] ctl_q;
    logic [15:0] status_q;
    logic [2:0] cs_s_q;
    logic [2:0] en_s_q;
    logic [2:0] tw_s_q;
    logic [2:0] ts_s_q;
    logic [2:0] sc_s_q;
    logic [2:0] uv_s_q;
    logic [5:0] ol_s1_q;
    logic [5:0] ol_s2_q;
    logic [5:0] ol_s3_q;
    logic en_q;
    logic tw_q;
    logic ts_q;
    logic sc_q;
    logic uv_q;
    logic [5:0] ol_q;
    logic short_flag_q;
    logic supply_flag_q;
    logic shut_flag_q;
    logic [5:0] sw_q;
    logic pull_q;
    logic dly_q;
    logic sout_q;
    logic soe_q;
    logic [15:0] rx_word;
    logic [4:0] rx_count;
    logic link_out;

    // Pack six switch fields of a word
    function automatic logic [5:0] sw_bits(input logic [15:0] w);
        sw_bits = {w[CTL_HIGH_C], w[CTL_LOW_C], w[CTL_HIGH_B], w[CTL_LOW_B],
                   w[CTL_HIGH_A], w[CTL_LOW_A]};
    endfunction

    bridge_link u_link (
        .link_clk(link_clk),
        .cs_n(cs_n),
        .serial_in(serial_in),
        .status_word(status_q),
        .serial_out(link_out),
        .rx_word(rx_word),
        .rx_count(rx_count)
    );

    // Three-stage synchronisers; change accepted when stages two and three agree
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cs_s_q <= 3'h7;
            en_s_q <= 3'h0;
            tw_s_q <= 3'h0;
            ts_s_q <= 3'h0;
            sc_s_q <= 3'h0;
            uv_s_q <= 3'h0;
            ol_s1_q <= SW_OFF;
            ol_s2_q <= SW_OFF;
            ol_s3_q <= SW_OFF;
        end
        else
        begin
            cs_s_q <= {cs_s_q[1:0], cs_n};
            en_s_q <= {en_s_q[1:0], hw_enable};
            tw_s_q <= {tw_s_q[1:0], temp_warn_in};
            ts_s_q <= {ts_s_q[1:0], temp_shut_in};
            sc_s_q <= {sc_s_q[1:0], short_in};
            uv_s_q <= {uv_s_q[1:0], uv_in};
            ol_s1_q <= open_in;
            ol_s2_q <= ol_s1_q;
            ol_s3_q <= ol_s2_q;
        end
    end

    // Filtered levels
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            en_q <= 1'b0;
            tw_q <= 1'b0;
            ts_q <= 1'b0;
            sc_q <= 1'b0;
            uv_q <= 1'b0;
            ol_q <= SW_OFF;
        end
        else
        begin
            if (en_s_q[1] == en_s_q[2]) en_q <= en_s_q[2];
            if (tw_s_q[1] == tw_s_q[2]) tw_q <= tw_s_q[2];
            if (ts_s_q[1] == ts_s_q[2]) ts_q <= ts_s_q[2];
            if (sc_s_q[1] == sc_s_q[2]) sc_q <= sc_s_q[2];
            if (uv_s_q[1] == uv_s_q[2]) uv_q <= uv_s_q[2];
            ol_q <= (ol_s2_q == ol_s3_q) ? ol_s3_q : ol_q;
        end
    end

    // Frame end: cs risen after a complete word; rx_word is then stable
    logic cs_q_prev;
    wire cs_rise = (cs_s_q[1] == cs_s_q[2]) && cs_s_q[2] && !cs_q_prev;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cs_q_prev <= 1'b1;
        else if (cs_s_q[1] == cs_s_q[2])
            cs_q_prev <= cs_s_q[2];
    end
    wire frame_ok = cs_rise && (rx_count == CNT_FULL);
    wire do_clear = frame_ok && rx_word[CTL_CLEAR];

    // Control word, applied only at cs rise
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ctl_q <= CTL_RESET;
        else if (frame_ok)
            ctl_q <= rx_word;
    end

    // Latched faults: a new event wins over the clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            short_flag_q <= 1'b0;
            supply_flag_q <= 1'b0;
            shut_flag_q <= 1'b0;
        end
        else
        begin
            short_flag_q <= sc_q | (short_flag_q & ~do_clear);
            supply_flag_q <= uv_q | (supply_flag_q & ~do_clear);
            shut_flag_q <= ts_q | (shut_flag_q & ~do_clear);
        end
    end

    // Effective enable and output gating
    wire eff_en = ctl_q[CTL_SOFT_EN] & en_q;
    wire open_mode = ~ctl_q[CTL_OPEN_N];
    wire outs_ok = eff_en & ~short_flag_q & ~shut_flag_q & ~uv_q;
    wire [5:0] sw_cmd = sw_bits(ctl_q);
    wire [5:0] sw_stat = open_mode ? ol_q : sw_q;
    wire [15:0] status_d = shut_flag_q ? ALL_ONES :
        {supply_flag_q, eff_en, short_flag_q, sw_stat[5:4], 2'b00,
         sw_stat[3:2], 2'b00, sw_stat[1:0], 2'b00, tw_q};

    // Outputs and status word registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sw_q <= SW_OFF;
            pull_q <= 1'b0;
            dly_q <= 1'b1;
            status_q <= ZERO_WORD;
        end
        else
        begin
            sw_q <= outs_ok ? sw_cmd : SW_OFF;
            pull_q <= open_mode;
            dly_q <= ctl_q[CTL_SHORT_DLY];
            status_q <= status_d;
        end
    end

    // Pin output: driven only while selected
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sout_q <= 1'b0;
            soe_q <= 1'b0;
        end
        else
        begin
            sout_q <= link_out;
            soe_q <= ~cs_s_q[1];
        end
    end

    assign serial_out = sout_q;
    assign serial_out_en = soe_q;
    assign switch_on = sw_q;
    assign open_pull_en = pull_q;
    assign short_delay_long = dly_q;
endmodule // bridge_ctrl

//--- test/bridge_ctrl_assertions.sv
// Port checker for the bridge control and status block
// Assumes the link clock stands low between frames
`timescale 1ns/1ps
module bridge_ctrl_checker
    import bridge_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic hw_enable,
    input wire logic temp_shut_in,
    input wire logic short_in,
    input wire logic uv_in,
    input wire logic [5:0] switch_on,
    input wire logic open_pull_en,
    input wire logic short_delay_long
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Output gating, link driver and stability relations
    a_pin_gate: assert property (!hw_enable [*6] |-> switch_on == SW_OFF)
        else $error("switches on while pin low");
    a_shut_gate: assert property (temp_shut_in [*7] |-> switch_on == SW_OFF)
        else $error("switches on during shutdown");
    a_uv_gate: assert property (uv_in [*6] |-> switch_on == SW_OFF)
        else $error("switches on during under-voltage");
    a_idle_hiz: assert property (cs_n [*6] |-> !serial_out_en)
        else $error("data out driven while deselected");
    a_drive_sel: assert property (!cs_n [*6] |-> serial_out_en)
        else $error("data out not driven in frame");
    a_apply_rise: assert property ((!cs_n && hw_enable && !short_in && !uv_in
        && !temp_shut_in) [*8] |-> $stable(switch_on))
        else $error("switches changed inside frame");
    a_mode_hold: assert property (!cs_n [*8] |-> $stable(open_pull_en)
        && $stable(short_delay_long))
        else $error("mode outputs changed inside frame");
    a_out_hold: assert property ((!cs_n && !link_clk) [*8] |-> $stable(serial_out))
        else $error("data out changed without rising clock");
    // Main scenarios reached
    c_on: cover property (switch_on != SW_OFF);
    c_pull: cover property (open_pull_en);
    c_drive: cover property (serial_out_en && !link_clk);
endmodule // bridge_ctrl_checker

bind bridge_ctrl bridge_ctrl_checker i_chk (.clock, .rst, .link_clk, .cs_n, .serial_out,
    .serial_out_en, .hw_enable, .temp_shut_in, .short_in, .uv_in, .switch_on,
    .open_pull_en, .short_delay_long);

//--- test/bridge_host_model.sv
// Host model that frames control words on the serial link
// Assumes data out is only valid while serial_out_en is high
`timescale 1ns/1ps
module bridge_host_model (
    output logic link_clk,
    output logic cs_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en
);
    // Idle link: deselected, clock low
    initial
    begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    // One frame of n bits, LSB first, clock still outside frames
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        cs_n = 1'b0;
        #125;
        for (int i = 0; i < n; i++)
        begin
            r[i] = serial_out_en ? serial_out : 1'bx;
            link_clk = 1'b1;
            serial_in = w[i];
            #62.5;
            link_clk = 1'b0;
            #62.5;
        end
        cs_n = 1'b1;
        serial_in = ~serial_in;
        #100;
    endtask
endmodule // bridge_host_model

//--- test/bridge_ctrl_tb.sv
// Testbench for the bridge control and status block
// Assumes the host model frames every access; monitors are driven here
`timescale 1ns/1ps
module bridge_ctrl_tb
    import bridge_pkg::*;
;
    logic clock, rst, hw_enable, temp_warn_in;
    logic [2:0] faults;
    logic [5:0] open_in;
    logic [15:0] rx;
    wire link_clk, cs_n, serial_in, serial_out, serial_out_en, open_pull_en, short_delay_long;
    wire [5:0] switch_on;
    int fail_count, total_checks;
    bridge_ctrl i_dut (.clock, .rst, .link_clk, .cs_n, .serial_in, .serial_out,
        .serial_out_en, .hw_enable, .temp_warn_in, .temp_shut_in(faults[2]),
        .short_in(faults[0]), .uv_in(faults[1]), .open_in, .switch_on, .open_pull_en,
        .short_delay_long);
    bridge_host_model i_host (.link_clk, .cs_n, .serial_in, .serial_out, .serial_out_en);
    // System clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (10) @(posedge clock);
    endtask
    task automatic wr(input logic [15:0] w);
        i_host.frame(w, 16, rx);
        settle();
    endtask
    task automatic rd(input logic [15:0] w, input logic [15:0] exp);
        wr(w);
        chk(rx, exp);
    endtask
    task automatic t_power_on();
        rd(CTL_RESET, 16'h4000);
        chk({14'h0000, open_pull_en, short_delay_long}, 16'h0001);
    endtask
    task automatic t_switches();
        logic [15:0] w[2] = '{16'hE908, 16'hF090};
        logic [5:0] s[2] = '{6'h19, 6'h26};
        for (int i = 0; i < 2; i++)
        begin
            wr(w[i]);
            chk({10'h000, switch_on}, {10'h000, s[i]});
            rd(w[i], (w[i] & 16'h1998) | 16'h4000);
        end
    endtask
    task automatic t_enable();
        @(posedge clock) hw_enable <= 1'b0;
        settle();
        rd(16'hE908, 16'h0000);
        @(posedge clock) hw_enable <= 1'b1;
        settle();
        rd(16'hE908, 16'h4908);
        rd(16'h6908, 16'h4908);
        rd(16'hE908, 16'h0000);
        rd(16'hE908, 16'h4908);
    endtask
    task automatic t_fault(input int k, input logic [15:0] ea, input logic [15:0] eb);
        @(posedge clock) faults[k] <= 1'b1;
        settle();
        rd(16'hE908, ea);
        chk({10'h000, switch_on}, 16'h0000);
        @(posedge clock) faults[k] <= 1'b0;
        settle();
        rd(16'hE909, eb);
        rd(16'hE908, 16'h4908);
    endtask
    task automatic t_prewarn();
        @(posedge clock) temp_warn_in <= 1'b1;
        settle();
        i_host.frame(16'h0000, 1, rx);
        settle();
        chk(rx, 16'h0001);
        chk({10'h000, switch_on}, 16'h0019);
        rd(16'hE908, 16'h4909);
        @(posedge clock) temp_warn_in <= 1'b0;
        settle();
        rd(16'hE908, 16'h4908);
    endtask
    task automatic t_open();
        wr(16'hE000);
        wr(16'hC000);
        chk({15'h0000, open_pull_en}, 16'h0001);
        @(posedge clock) open_in <= 6'h05;
        settle();
        rd(16'hC000, 16'h4088);
        @(posedge clock) open_in <= 6'h00;
        settle();
        rd(16'hC000, 16'h4000);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #300000;
        fail_count++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        hw_enable = 1'b1;
        temp_warn_in = 1'b0;
        faults = 3'h0;
        open_in = 6'h00;
        fail_count = 0;
        total_checks = 0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        settle();
        t_power_on();
        t_switches();
        t_enable();
        t_fault(0, 16'h6000, 16'h6000);
        t_fault(1, 16'hC000, 16'hC908);
        t_fault(2, 16'hFFFF, 16'hFFFF);
        t_prewarn();
        t_open();
        report_and_stop();
    end
endmodule // bridge_ctrl_tb
